// ### nvss_host.sv
// nvss_host: host controller driving an 8K x 8 nvSRAM over its pins
// assumes one request port on CLK; the memory pins are asynchronous
// Operation
// R1: save/reload use six reads, first five at 0000,1555,0AAA,1FFF,10F0.
// R2: sixth read at 0F0F starts a save; chip then disabled.
// R3: sixth read at 0F0E starts a reload of the array.
// R4: any out-of-order access aborts the sequence; nothing starts.
// R5: host uses only read cycles inside a sequence.
// R6: sequence detection ignores output enable.
// R7: during a save device ignores inputs, outputs stay off.
// R8: save erases then programs all cells in parallel.
// R9: after save duration, normal access resumes.
// R10: reload clears the array, then transfers saved data.
// R11: reload leaves saved data intact; repeatable.
// R12: device reloads automatically once supply passes threshold.
// R13: host waits power-up reload time before any access.
// R14: host keeps write enable high when power-up reload ends.
// R15: device refuses save when supply is below threshold.
// R16: started operations finish on their own, ignoring inputs.
// R17: chip enable pulses once for each of the six reads.
// R18: write enable stays high through all six cycles.
// R19: host never issues the reserved test sixth address.
// R20: after an abort, a read of 0000 restarts detection.
// R21: sequence reads still return array data.
`timescale 1ns/1ns
`default_nettype none
module nvss_host
#(
  parameter int SAVE_WAIT = nvss_pkg::SAVE_CYC,
  parameter int RELOAD_WAIT = nvss_pkg::RELOAD_CYC,
  parameter int RECALL_WAIT = nvss_pkg::RECALL_CYC
)
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic REQ_VALID,
  output logic REQ_READY,
  input wire nvss_pkg::nvss_req_t REQ,
  output logic RSP_VALID,
  output logic [7:0] RSP_DATA,
  output logic MEM_E_N,
  output logic MEM_W_N,
  output logic MEM_G_N,
  output logic [12:0] MEM_A,
  input wire logic [7:0] MEM_DQ_I,
  output logic [7:0] MEM_DQ_O,
  output logic MEM_DQ_OE,
  output logic BUSY
);

  // ==========================================================
  // reset release
  logic rst_s1_q;
  logic rst_n_q;
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  // ==========================================================
  // data input synchroniser
  logic [7:0] dq_s1_q;
  logic [7:0] dq_s2_q;
  always_ff @(posedge CLK or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      dq_s1_q <= 8'h00;
      dq_s2_q <= 8'h00;
    end
    else
    begin
      dq_s1_q <= MEM_DQ_I;
      dq_s2_q <= dq_s1_q;
    end
  end

  // ==========================================================
  // state machine
  typedef enum logic [2:0]
  {
    ST_PWRUP = 3'b000,
    ST_IDLE = 3'b001,
    ST_SETUP = 3'b010,
    ST_STROBE = 3'b011,
    ST_GAP = 3'b100,
    ST_WAIT = 3'b101
  } nvss_state_t;

  nvss_state_t state_q;
  logic [31:0] cnt_q;
  logic [2:0] step_q;
  logic seq_q;
  logic save_q;
  logic write_q;
  logic [12:0] addr_q;
  logic [7:0] wdata_q;
  logic [12:0] seq_addr;
  logic last_step;
  nvss_addr_rom u_rom
  (
    .clk(CLK),
    .rst_n(rst_n_q),
    .idx(step_q),
    .save(save_q),
    .addr(seq_addr)
  );
  assign last_step = (step_q == 3'd5);
  assign REQ_READY = (state_q == ST_IDLE);
  assign BUSY = (state_q != ST_IDLE);
  always_ff @(posedge CLK or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      state_q <= ST_PWRUP;
      cnt_q <= 32'h0;
      step_q <= 3'd0;
      seq_q <= 1'b0;
      save_q <= 1'b0;
      write_q <= 1'b0;
      wdata_q <= 8'h00;
    end
    else
    begin
      unique case (state_q)
        // R13: hold off until reload done
        ST_PWRUP:
        begin
          cnt_q <= cnt_q + 32'h1;
          if (cnt_q >= 32'(RELOAD_WAIT - 1))
          begin
            state_q <= ST_IDLE;
            cnt_q <= 32'h0;
          end
        end
        ST_IDLE:
        begin
          if (REQ_VALID)
          begin
            write_q <= (REQ.cmd == nvss_pkg::NVSS_CMD_WRITE);
            seq_q <= REQ.cmd[1];
            save_q <= (REQ.cmd == nvss_pkg::NVSS_CMD_SAVE);
            wdata_q <= REQ.wdata;
            step_q <= 3'd0;
            state_q <= ST_SETUP;
          end
        end
        ST_SETUP:
        begin
          state_q <= ST_STROBE;
          cnt_q <= 32'h0;
        end
        // R17: one enable pulse per read
        ST_STROBE:
        begin
          cnt_q <= cnt_q + 32'h1;
          if (cnt_q >= 32'(nvss_pkg::ACC_CYC - 1))
          begin
            cnt_q <= 32'h0;
            state_q <= ST_GAP;
          end
        end
        ST_GAP:
        begin
          if (seq_q && !last_step)
          begin
            step_q <= step_q + 3'd1;
            state_q <= ST_SETUP;
          end
          else if (seq_q)
          begin
            state_q <= ST_WAIT;
          end
          else
          begin
            state_q <= ST_IDLE;
          end
        end
        // R16: wait out the autonomous operation
        ST_WAIT:
        begin
          cnt_q <= cnt_q + 32'h1;
          if (cnt_q >= 32'(save_q ? SAVE_WAIT - 1 : RECALL_WAIT - 1))
          begin
            cnt_q <= 32'h0;
            seq_q <= 1'b0;
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // address and response
  always_ff @(posedge CLK or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      addr_q <= 13'h0000;
    end
    else if (state_q == ST_IDLE && REQ_VALID)
    begin
      addr_q <= REQ.addr;
    end
  end

  always_ff @(posedge CLK or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      RSP_VALID <= 1'b0;
      RSP_DATA <= 8'h00;
    end
    else
    begin
      RSP_VALID <= (state_q == ST_GAP) && !write_q && !seq_q;
      RSP_DATA <= (state_q == ST_GAP) ? dq_s2_q : RSP_DATA;
    end
  end

  // ==========================================================
  // pins
  always_ff @(posedge CLK or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      MEM_E_N <= 1'b1;
      MEM_W_N <= 1'b1;
      MEM_G_N <= 1'b1;
      MEM_A <= 13'h0000;
      MEM_DQ_O <= 8'h00;
      MEM_DQ_OE <= 1'b0;
    end
    else
    begin
      MEM_E_N <= (state_q != ST_STROBE)
                 || (cnt_q >= 32'(nvss_pkg::ACC_CYC - 1));
      // R5 R18: sequence reads only, write enable high
      // R14: write enable idles high
      MEM_W_N <= !(write_q && !seq_q && state_q == ST_STROBE
                   && cnt_q < 32'(nvss_pkg::ACC_CYC - 1));
      MEM_G_N <= write_q || seq_q || state_q != ST_STROBE;
      MEM_A <= seq_q ? seq_addr : addr_q;
      MEM_DQ_O <= wdata_q;
      MEM_DQ_OE <= write_q && !seq_q
                   && (state_q == ST_SETUP || state_q == ST_STROBE);
    end
  end

  // ==========================================================
  // checks
  // R18: no write strobe inside a sequence
  AST_SEQ_NO_WRITE: assert property (@(posedge CLK) disable iff (!rst_n_q)
    seq_q |-> MEM_W_N) else $error("write enable low in sequence"); // R18
  // R1: six strobes precede the wait
  AST_SIX_STEPS: assert property (@(posedge CLK) disable iff (!rst_n_q)
    $rose(state_q == ST_WAIT) |-> $past(step_q) == 3'd5)
    else $error("wait without six steps"); // R1
  // R13: no access while powering up
  AST_PWRUP_QUIET: assert property (@(posedge CLK) disable iff (!rst_n_q)
    state_q == ST_PWRUP |=> MEM_E_N) else $error("access in power-up"); // R13
  // R19: never the test address
  AST_NO_TEST: assert property (@(posedge CLK) disable iff (!rst_n_q)
    !MEM_E_N |-> MEM_A != nvss_pkg::SEQ_TEST)
    else $error("test address driven"); // R19
  // R16: chip stays idle during wait
  AST_WAIT_IDLE: assert property (@(posedge CLK) disable iff (!rst_n_q)
    state_q == ST_WAIT ##1 state_q == ST_WAIT |-> MEM_E_N)
    else $error("access during operation"); // R16
  // R17: enable pulses high between steps
  AST_STEP_GAP: assert property (@(posedge CLK) disable iff (!rst_n_q)
    state_q == ST_GAP |=> MEM_E_N) else $error("no enable gap"); // R17
  // R14: write enable released at idle
  AST_IDLE_W: assert property (@(posedge CLK) disable iff (!rst_n_q)
    state_q == ST_IDLE ##1 state_q == ST_IDLE |-> MEM_W_N)
    else $error("write held at idle"); // R14
  // R5: data bus not driven in sequence
  AST_SEQ_NO_DRIVE: assert property (@(posedge CLK) disable iff (!rst_n_q)
    seq_q ##1 seq_q |-> !MEM_DQ_OE) else $error("bus driven in sequence"); // R5
  // R17: address steady under enable
  AST_ADDR_HOLD: assert property (@(posedge CLK) disable iff (!rst_n_q)
    !MEM_E_N ##1 !MEM_E_N |-> $stable(MEM_A))
    else $error("address moved under enable"); // R17

endmodule : nvss_host
`default_nettype wire

// ### nvss_pkg.sv
// nvss_pkg: constants and carrier types for the nonvolatile sequence host
// assumes a 50 MHz system clock and an asynchronous 8K x 8 nvSRAM outside
`default_nettype none
package nvss_pkg;

  // ==========================================================
  // sequence addresses
  localparam logic [12:0] SEQ_A0 = 13'h0000;
  localparam logic [12:0] SEQ_A1 = 13'h1555;
  localparam logic [12:0] SEQ_A2 = 13'h0aaa;
  localparam logic [12:0] SEQ_A3 = 13'h1fff;
  localparam logic [12:0] SEQ_A4 = 13'h10f0;
  localparam logic [12:0] SEQ_SAVE = 13'h0f0f;
  localparam logic [12:0] SEQ_RELOAD = 13'h0f0e;
  localparam logic [12:0] SEQ_TEST = 13'h139c;

  // ==========================================================
  // timing
  localparam int CLK_MHZ = 50;
  localparam int ACC_NS = 100;
  localparam int ACC_CYC = (ACC_NS * CLK_MHZ + 999) / 1000;
  localparam int NONVOLATILE_SAVE_DURATION_MS = 10;
  localparam int SAVE_CYC = NONVOLATILE_SAVE_DURATION_MS * CLK_MHZ * 1000;
  localparam int RECALL_US = 20;
  localparam int RECALL_CYC = RECALL_US * CLK_MHZ;
  localparam int POWER_UP_RELOAD_TIME_US = 20;
  localparam int RELOAD_CYC = POWER_UP_RELOAD_TIME_US * CLK_MHZ;

  // ==========================================================
  // command carrier
  typedef enum logic [1:0]
  {
    NVSS_CMD_READ = 2'b00,
    NVSS_CMD_WRITE = 2'b01,
    NVSS_CMD_SAVE = 2'b10,
    NVSS_CMD_RELOAD = 2'b11
  } nvss_cmd_t;

  typedef struct packed
  {
    nvss_cmd_t cmd;
    logic [12:0] addr;
    logic [7:0] wdata;
  } nvss_req_t;

  typedef struct packed
  {
    logic n_e;
    logic n_w;
    logic n_g;
    logic [12:0] addr;
  } nvss_pins_t;

endpackage : nvss_pkg
`default_nettype wire

// ### nvss_addr_rom.sv
// nvss_addr_rom: registered table of the six sequence addresses
// assumes the caller holds the index stable for one cycle before use
`timescale 1ns/1ns
`default_nettype none
module nvss_addr_rom
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [2:0] idx,
  input wire logic save,
  output logic [12:0] addr
);

  // ==========================================================
  // address table
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      addr <= 13'h0000;
    end
    else
    begin
      // R1: fixed address order
      unique case (idx)
        3'd0: addr <= nvss_pkg::SEQ_A0;
        3'd1: addr <= nvss_pkg::SEQ_A1;
        3'd2: addr <= nvss_pkg::SEQ_A2;
        3'd3: addr <= nvss_pkg::SEQ_A3;
        3'd4: addr <= nvss_pkg::SEQ_A4;
        // R19: never the test address
        default: addr <= save ? nvss_pkg::SEQ_SAVE : nvss_pkg::SEQ_RELOAD;
      endcase
    end
  end

endmodule : nvss_addr_rom
`default_nettype wire

// ### nvss_mem_model.sv
// nvss_mem_model: behavioural 8K x 8 nvSRAM on the host pins
// assumes the host drives the pins; shadow preset with a byte pattern
`timescale 1ns/1ns
`default_nettype none
module nvss_mem_model
#(
  parameter int OP_NS = 300
)
(
  input wire logic e_n,
  input wire logic w_n,
  input wire logic g_n,
  input wire logic [12:0] a,
  input wire logic [7:0] dq_in,
  input wire logic supply_low,
  output logic [7:0] dq,
  output int stores,
  output int recalls,
  output int errs
);
  // ==========================================================
  // storage
  logic [7:0] ram [8192];
  logic [7:0] ee [8192];
  logic [12:0] seq [5] = '{13'h0000, 13'h1555, 13'h0aaa, 13'h1fff, 13'h10f0};
  logic busy = 1'b1;
  logic saw_w = 1'b0;
  int step = 0;

  task automatic reload;
    ram = '{default: 8'h00};
    #(OP_NS);
    ram = ee;
    recalls++;
  endtask : reload

  initial
  begin
    stores = 0;
    recalls = 0;
    errs = 0;
    for (int i = 0; i < 8192; i++)
      ee[i] = i[7:0] ^ 8'h3c;
    reload();
    busy = 1'b0;
  end

  // ==========================================================
  // pins
  // strobe while busy counted
  always @(negedge e_n)
    if (busy)
      errs++;

  // write lands and breaks the sequence
  always @(e_n, w_n, a, dq_in)
    if (!e_n && !w_n && !busy)
    begin
      ram[a] = dq_in;
      saw_w = 1'b1;
    end

  always @(posedge e_n)
  begin
    if (busy || saw_w)
      step = 0;
    else if (step < 5)
      step = (a == seq[step]) ? step + 1 : int'(a == 13'h0000);
    else
    begin
      step = int'(a == 13'h0000);
      if (a == 13'h139c)
        errs++;
      // no save while the supply sits below threshold
      busy = ((a == 13'h0f0f) && !supply_low) || (a == 13'h0f0e);
      if ((a == 13'h0f0f) && !supply_low)
      begin
        ee = '{default: 8'hff};
        #(OP_NS);
        ee = ram;
        stores++;
      end
      if (a == 13'h0f0e)
        reload();
      busy = 1'b0;
    end
    saw_w = 1'b0;
  end

  // array data on an enabled read, inverted array data otherwise
  assign dq = (!e_n && !g_n && w_n && !busy) ? ram[a] : ~ram[a];
endmodule : nvss_mem_model
`default_nettype wire

// ### nvss_host_tb.sv
// nvss_host_tb: scenarios for the nvSRAM host against the memory model
// assumes shortened wait parameters and a 50 MHz clock
`timescale 1ns/1ns
`default_nettype none
module nvss_host_tb;
  logic CLK = 1'b0;
  logic RST_N = 1'b0;
  logic REQ_VALID = 1'b0;
  nvss_pkg::nvss_req_t REQ = '0;
  logic REQ_READY, RSP_VALID, MEM_E_N, MEM_W_N, MEM_G_N, MEM_DQ_OE, BUSY;
  logic [7:0] RSP_DATA, MEM_DQ_O, mdq;
  logic [12:0] MEM_A;
  int stores, recalls, errs;
  logic supply_low = 1'b0;
  int fails = 0;
  int check_count = 0;
  wire logic [7:0] dq_bus = MEM_DQ_OE ? MEM_DQ_O : mdq;

  // ==========================================================
  // structure
  nvss_host #(.SAVE_WAIT(20), .RELOAD_WAIT(20), .RECALL_WAIT(20)) dut
  (
    .CLK(CLK), .RST_N(RST_N), .REQ_VALID(REQ_VALID), .REQ_READY(REQ_READY),
    .REQ(REQ), .RSP_VALID(RSP_VALID), .RSP_DATA(RSP_DATA),
    .MEM_E_N(MEM_E_N), .MEM_W_N(MEM_W_N), .MEM_G_N(MEM_G_N), .MEM_A(MEM_A),
    .MEM_DQ_I(dq_bus), .MEM_DQ_O(MEM_DQ_O), .MEM_DQ_OE(MEM_DQ_OE),
    .BUSY(BUSY)
  );
  nvss_mem_model mem
  (
    .e_n(MEM_E_N), .w_n(MEM_W_N), .g_n(MEM_G_N), .a(MEM_A), .dq_in(dq_bus),
    .supply_low(supply_low),
    .dq(mdq), .stores(stores), .recalls(recalls), .errs(errs)
  );

  initial
  begin
    forever #10 CLK = ~CLK;
  end

  // ==========================================================
  // helpers
  task automatic results;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : results

  task automatic chk(input string what, input logic [31:0] exp, got);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s exp %h got %h", what, exp, got);
    end
  endtask : chk

  task automatic req(input nvss_pkg::nvss_cmd_t c, input logic [12:0] ad,
    input logic [7:0] wd);
    for (int n = 0; n < 2000 && REQ_READY !== 1'b1; n++)
      @(negedge CLK);
    REQ = '{cmd: c, addr: ad, wdata: wd};
    REQ_VALID = 1'b1;
    @(negedge CLK);
    REQ_VALID = 1'b0;
  endtask : req

  task automatic idle;
    @(negedge CLK);
    for (int n = 0; n < 5000 && BUSY !== 1'b0; n++)
      @(negedge CLK);
    chk("busy", 32'h0, BUSY);
  endtask : idle

  task automatic rd(input logic [12:0] ad, input logic [7:0] exp);
    req(nvss_pkg::NVSS_CMD_READ, ad, 8'h00);
    for (int n = 0; n < 50 && RSP_VALID !== 1'b1; n++)
      @(negedge CLK);
    chk("rsp_valid", 32'h1, RSP_VALID);
    chk("rsp_data", exp, RSP_DATA);
  endtask : rd

  // ==========================================================
  // scenarios
  task automatic t_power;
    chk("busy", 32'h1, BUSY);
    chk("ready", 32'h0, REQ_READY);
    chk("e_n", 32'h1, MEM_E_N);
    idle();
    chk("recalls", 32'h1, recalls);
    rd(13'h0005, 8'h39);
    chk("errs", 32'h0, errs);
  endtask : t_power

  task automatic t_save;
    req(nvss_pkg::NVSS_CMD_WRITE, 13'h0005, 8'ha5);
    rd(13'h0005, 8'ha5);
    req(nvss_pkg::NVSS_CMD_SAVE, 13'h0000, 8'h00);
    idle();
    chk("stores", 32'h1, stores);
    chk("errs", 32'h0, errs);
    rd(13'h0005, 8'ha5);
  endtask : t_save

  task automatic t_reload;
    req(nvss_pkg::NVSS_CMD_WRITE, 13'h0005, 8'h11);
    req(nvss_pkg::NVSS_CMD_WRITE, 13'h0007, 8'h22);
    rd(13'h0005, 8'h11);
    req(nvss_pkg::NVSS_CMD_RELOAD, 13'h0000, 8'h00);
    idle();
    chk("recalls", 32'h2, recalls);
    rd(13'h0005, 8'ha5);
    rd(13'h0007, 8'h3b);
    req(nvss_pkg::NVSS_CMD_RELOAD, 13'h0000, 8'h00);
    idle();
    chk("recalls", 32'h3, recalls);
    rd(13'h0005, 8'ha5);
    chk("errs", 32'h0, errs);
  endtask : t_reload

  task automatic t_abort;
    logic [12:0] seq [8] = '{13'h0000, 13'h1555, 13'h0006, 13'h0000,
      13'h1555, 13'h0aaa, 13'h1fff, 13'h10f0};
    foreach (seq[i])
      rd(seq[i], seq[i][7:0] ^ 8'h3c);
    req(nvss_pkg::NVSS_CMD_WRITE, 13'h0f0e, 8'h00);
    idle();
    chk("recalls", 32'h3, recalls);
    chk("stores", 32'h1, stores);
    supply_low = 1'b1;
    req(nvss_pkg::NVSS_CMD_SAVE, 13'h0000, 8'h00);
    idle();
    chk("stores", 32'h1, stores);
    chk("errs", 32'h0, errs);
    supply_low = 1'b0;
  endtask : t_abort

  initial
  begin
    #200000;
    fails++;
    results();
  end

  initial
  begin
    repeat (5) @(negedge CLK);
    RST_N = 1'b1;
    @(negedge CLK);
    t_power();
    t_save();
    t_reload();
    t_abort();
    results();
  end
endmodule : nvss_host_tb
`default_nettype wire
